// >>> verilog/pmp_cfg.svh
`ifndef PMP_CFG_SVH
`define PMP_CFG_SVH

// register offsets on the plain register port
`define PMP_OFS_CONH   12'hF50
`define PMP_OFS_CONL   12'hF51
`define PMP_OFS_MODEH  12'hF52
`define PMP_OFS_MODEL  12'hF53
`define PMP_OFS_ADRL   12'hF54
`define PMP_OFS_ADRH   12'hF55
`define PMP_OFS_ENL    12'hF56
`define PMP_OFS_ENH    12'hF57
`define PMP_OFS_DATL   12'hF58
`define PMP_OFS_DATH   12'hF59
`define PMP_OFS_STAT   12'hF5A
`define PMP_OFS_MASK   12'hF5B
`define PMP_OFS_PIE    12'hF9D
`define PMP_REG_RST    8'h00

// control high fields
`define PMP_ON         7
`define PMP_MUX_HI     4
`define PMP_MUX_LO     3
`define PMP_BEEN       2
`define PMP_WREN       1
`define PMP_RDEN       0
// control low fields: polarity (1 = active high) and chip select function
`define PMP_POL_RD     0
`define PMP_POL_WR     1
`define PMP_POL_BE     2
`define PMP_POL_AL     3
`define PMP_POL_CS1    4
`define PMP_POL_CS2    5
`define PMP_CSF1       6
`define PMP_CSF2       7
// mode high fields
`define PMP_MODE_HI    1
`define PMP_MODE_LO    0
`define PMP_WIDE       2
`define PMP_INC_HI     4
`define PMP_INC_LO     3
// mode low fields: wait counts
`define PMP_WB_HI      7
`define PMP_WB_LO      6
`define PMP_WM_HI      5
`define PMP_WM_LO      2
`define PMP_WE_HI      1
`define PMP_WE_LO      0
// status, mask, irq enable
`define PMP_DONE       0
`define PMP_BUSY       7
`define PMP_PIE_PORT   7

// encodings
`define PMP_MODE_M2    2'b10
`define PMP_MODE_M1    2'b11
`define PMP_MUX_DEMUX  2'b00
`define PMP_MUX_PART   2'b01
`define PMP_MUX_FULL   2'b10
`define PMP_INC_UP     2'b01
`define PMP_INC_DN     2'b10

// pin vector layout
`define PMP_NPIN       27
`define PMP_PIN_ALL    0
`define PMP_PIN_ALH    1
`define PMP_PIN_CS1    14
`define PMP_PIN_CS2    15
`define PMP_PIN_RD     16
`define PMP_PIN_WR     17
`define PMP_PIN_BE     18
`define PMP_PIN_DAT    19

`endif

// >>> verilog/pmp_pkg.sv
package pmp_pkg;

  // transfer sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ALL  = 6'h02,
    ST_ALH  = 6'h04,
    ST_BEG  = 6'h08,
    ST_MID  = 6'h10,
    ST_END  = 6'h20
  } pmp_state_type;

endpackage

// >>> verilog/pmp_if.sv
`timescale 1ns/1ps
// pin function values from the sequencer to the pad stage
interface pmp_if #(
  parameter int N = 27
);
  logic [N-1:0] fn_en;
  logic [N-1:0] fn_val;
  logic [N-1:0] fn_oe;
  modport core (output fn_en, output fn_val, output fn_oe);
  modport pad  (input fn_en, input fn_val, input fn_oe);
endinterface

// >>> verilog/pmp_pad.sv
`timescale 1ns/1ps
// registered pin mux: port function or general I/O per pin
module pmp_pad #(
  parameter int N = 27
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  pmp_if.pad                fn,
  input  wire logic [N-1:0] gpio_o,
  input  wire logic [N-1:0] gpio_oe,
  output logic      [N-1:0] pin_o,
  output logic      [N-1:0] pin_oe
);

  // one flop pair per pin
  for (genvar i = 0; i < N; i++)
  begin : g_pin
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        pin_o[i]  <= 1'b0;
        pin_oe[i] <= 1'b0;
      end
      else
      begin
        pin_o[i]  <= fn.fn_en[i] ? fn.fn_val[i] : gpio_o[i];
        pin_oe[i] <= fn.fn_en[i] ? fn.fn_oe[i] : gpio_oe[i];
      end
    end
  end

endmodule

// >>> verilog/pmp_master.sv
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`include "pmp_cfg.svh"
module pmp_master
  import pmp_pkg::*;
#(
  parameter int AW = 16,
  parameter int DW = 8
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic [11:0]          reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [7:0]           reg_rdata,
  output logic                      irq,
  output logic      [AW-1:0]        address_pins_o,
  output logic      [AW-1:0]        address_pins_oe,
  output logic                      read_strobe_o,
  output logic                      read_strobe_oe,
  output logic                      write_strobe_o,
  output logic                      write_strobe_oe,
  output logic                      byte_enable_strobe_o,
  output logic                      byte_enable_strobe_oe,
  output logic      [DW-1:0]        port_data_pins_o,
  output logic      [DW-1:0]        port_data_pins_oe,
  input  wire logic [DW-1:0]        port_data_pins_i,
  input  wire logic [`PMP_NPIN-1:0] gpio_o,
  input  wire logic [`PMP_NPIN-1:0] gpio_oe
);

  logic [7:0]          conh_q;
  logic [7:0]          conl_q;
  logic [7:0]          modeh_q;
  logic [7:0]          model_q;
  logic [15:0]         addr_q;
  logic [7:0]          enl_q;
  logic [7:0]          enh_q;
  logic [7:0]          pie_q;
  logic [15:0]         dout_q;
  logic [15:0]         din_q;
  logic                done_q;
  logic                msk_q;
  logic [7:0]          rdata_q;
  logic                irq_q;
  pmp_state_type       st_q;
  logic [3:0]          cnt_q;
  logic                hi_q;
  logic                rd_q;
  logic                master;
  logic                start_wr;
  logic                start_rd;
  logic                fin;
  logic [1:0]          mode;
  logic [1:0]          mux;
  logic [15:0]         pin_en;
  logic [7:0]          hi_addr;
  logic [`PMP_NPIN-1:0] pin_o;
  logic [`PMP_NPIN-1:0] pin_oe;

  pmp_if #(.N(`PMP_NPIN)) fn_bus ();

  assign mode = modeh_q[`PMP_MODE_HI:`PMP_MODE_LO];
  assign mux  = conh_q[`PMP_MUX_HI:`PMP_MUX_LO];

  // master operation qualifier
  assign master = conh_q[`PMP_ON]
                  && (mode == `PMP_MODE_M1 || mode == `PMP_MODE_M2);
  assign start_wr = reg_wr && reg_addr == `PMP_OFS_DATL && master && st_q == ST_IDLE;
  assign start_rd = reg_rd && reg_addr == `PMP_OFS_DATL && master && st_q == ST_IDLE;
  // last cycle of the last byte
  assign fin = st_q == ST_END && cnt_q == 4'h0
               && !(modeh_q[`PMP_WIDE] && !hi_q);
  assign pin_en = {enh_q, enl_q};

  // configuration registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      conh_q  <= `PMP_REG_RST;
      conl_q  <= `PMP_REG_RST;
      modeh_q <= `PMP_REG_RST;
      model_q <= `PMP_REG_RST;
      enl_q   <= `PMP_REG_RST;
      enh_q   <= `PMP_REG_RST;
      pie_q   <= `PMP_REG_RST;
      msk_q   <= 1'b0;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        `PMP_OFS_CONH:  conh_q  <= reg_wdata;
        `PMP_OFS_CONL:  conl_q  <= reg_wdata;
        `PMP_OFS_MODEH: modeh_q <= reg_wdata;
        `PMP_OFS_MODEL: model_q <= reg_wdata;
        `PMP_OFS_ENL:   enl_q   <= reg_wdata;
        `PMP_OFS_ENH:   enh_q   <= reg_wdata;
        `PMP_OFS_PIE:   pie_q   <= reg_wdata;
        `PMP_OFS_MASK:  msk_q   <= reg_wdata[`PMP_DONE];
        default:        ;
      endcase
    end
  end

  // write data buffer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      dout_q <= 16'h0000;
    else if (reg_wr && reg_addr == `PMP_OFS_DATH)
      dout_q[15:8] <= reg_wdata;
    else if (reg_wr && reg_addr == `PMP_OFS_DATL && st_q == ST_IDLE)
      dout_q[7:0] <= reg_wdata;
  end

  // address register: software writes, auto step after each access
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      addr_q <= 16'h0000;
    else if (reg_wr && reg_addr == `PMP_OFS_ADRL)
      addr_q[7:0] <= reg_wdata;
    else if (reg_wr && reg_addr == `PMP_OFS_ADRH)
      addr_q[15:8] <= reg_wdata;
    else if (fin && modeh_q[`PMP_INC_HI:`PMP_INC_LO] == `PMP_INC_UP)
      addr_q <= addr_q + 16'h0001;
    else if (fin && modeh_q[`PMP_INC_HI:`PMP_INC_LO] == `PMP_INC_DN)
      addr_q <= addr_q - 16'h0001;
  end

  // transfer sequencer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q  <= ST_IDLE;
      cnt_q <= 4'h0;
      hi_q  <= 1'b0;
      rd_q  <= 1'b0;
    end
    else if (!master)
    begin
      st_q <= ST_IDLE;
      hi_q <= 1'b0;
    end
    else
    begin
      unique case (st_q)
        ST_IDLE:
        begin
          hi_q <= 1'b0;
          if (start_wr || start_rd)
          begin
            rd_q  <= start_rd;
            cnt_q <= {2'b00, model_q[`PMP_WB_HI:`PMP_WB_LO]};
            st_q  <= (mux == `PMP_MUX_DEMUX) ? ST_BEG : ST_ALL;
          end
        end
        ST_ALL:
          st_q <= (mux == `PMP_MUX_FULL) ? ST_ALH : ST_BEG;
        ST_ALH:
          st_q <= ST_BEG;
        ST_BEG:
        begin
          if (cnt_q == 4'h0)
          begin
            cnt_q <= model_q[`PMP_WM_HI:`PMP_WM_LO];
            st_q  <= ST_MID;
          end
          else
            cnt_q <= cnt_q - 4'h1;
        end
        ST_MID:
        begin
          if (cnt_q == 4'h0)
          begin
            cnt_q <= {2'b00, model_q[`PMP_WE_HI:`PMP_WE_LO]};
            st_q  <= ST_END;
          end
          else
            cnt_q <= cnt_q - 4'h1;
        end
        ST_END:
        begin
          if (cnt_q != 4'h0)
            cnt_q <= cnt_q - 4'h1;
          else if (modeh_q[`PMP_WIDE] && !hi_q)
          begin
            hi_q  <= 1'b1;
            cnt_q <= {2'b00, model_q[`PMP_WB_HI:`PMP_WB_LO]};
            st_q  <= ST_BEG;
          end
          else
            st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // read data capture at the close of each byte
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      din_q <= 16'h0000;
    else if (st_q == ST_END && cnt_q == 4'h0 && rd_q)
    begin
      if (hi_q)
        din_q[15:8] <= port_data_pins_i;
      else
        din_q[7:0] <= port_data_pins_i;
    end
  end

  // completion flag: set beats a write-one clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      done_q <= 1'b0;
    else if (fin)
      done_q <= 1'b1;
    else if (reg_wr && reg_addr == `PMP_OFS_STAT && reg_wdata[`PMP_DONE])
      done_q <= 1'b0;
  end

  // level interrupt, gated by mask and port irq enable
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_q <= 1'b0;
    else
      irq_q <= done_q && msk_q && pie_q[`PMP_PIE_PORT];
  end

  // register read port, data one cycle later
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_q <= 8'h00;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        `PMP_OFS_CONH:  rdata_q <= conh_q;
        `PMP_OFS_CONL:  rdata_q <= conl_q;
        `PMP_OFS_MODEH: rdata_q <= modeh_q;
        `PMP_OFS_MODEL: rdata_q <= model_q;
        `PMP_OFS_ADRL:  rdata_q <= addr_q[7:0];
        `PMP_OFS_ADRH:  rdata_q <= addr_q[15:8];
        `PMP_OFS_ENL:   rdata_q <= enl_q;
        `PMP_OFS_ENH:   rdata_q <= enh_q;
        `PMP_OFS_PIE:   rdata_q <= pie_q;
        `PMP_OFS_DATL:  rdata_q <= din_q[7:0];
        `PMP_OFS_DATH:  rdata_q <= din_q[15:8];
        `PMP_OFS_STAT:  rdata_q <= {st_q != ST_IDLE, 6'h00, done_q};
        `PMP_OFS_MASK:  rdata_q <= {7'h00, msk_q};
        default:        rdata_q <= 8'h00;
      endcase
    end
  end

  // high address byte with chip select bits forced low
  always_comb
  begin
    hi_addr = addr_q[15:8];
    if (conl_q[`PMP_CSF1])
      hi_addr[`PMP_PIN_CS1 - 8] = 1'b0;
    if (conl_q[`PMP_CSF2])
      hi_addr[`PMP_PIN_CS2 - 8] = 1'b0;
  end

  // pin function values, enables and drive for the pad stage
  always_comb
  begin
    logic act;
    logic strb;
    logic byte_ph;
    act     = st_q != ST_IDLE;
    strb    = st_q == ST_MID;
    byte_ph = st_q == ST_BEG || strb || st_q == ST_END;
    fn_bus.fn_oe  = '1;
    fn_bus.fn_val = '0;
    fn_bus.fn_en  = '0;
    // address pins and their enables
    fn_bus.fn_val[15:0] = addr_q;
    fn_bus.fn_en[15:0]  = master ? pin_en : 16'h0000;
    if (mux != `PMP_MUX_DEMUX)
      fn_bus.fn_val[`PMP_PIN_ALL] =
        conl_q[`PMP_POL_AL] ~^ (st_q == ST_ALL);
    if (mux == `PMP_MUX_FULL)
      fn_bus.fn_val[`PMP_PIN_ALH] =
        conl_q[`PMP_POL_AL] ~^ (st_q == ST_ALH);
    if (conl_q[`PMP_CSF1])
      fn_bus.fn_val[`PMP_PIN_CS1] = conl_q[`PMP_POL_CS1] ~^ act;
    if (conl_q[`PMP_CSF2])
      fn_bus.fn_val[`PMP_PIN_CS2] = conl_q[`PMP_POL_CS2] ~^ act;
    // read and write pins per master mode
    if (mode == `PMP_MODE_M1)
    begin
      fn_bus.fn_val[`PMP_PIN_RD] = conl_q[`PMP_POL_RD] ~^ (act && rd_q);
      fn_bus.fn_val[`PMP_PIN_WR] = conl_q[`PMP_POL_WR] ~^ strb;
    end
    else
    begin
      fn_bus.fn_val[`PMP_PIN_RD] = conl_q[`PMP_POL_RD] ~^ (strb && rd_q);
      fn_bus.fn_val[`PMP_PIN_WR] = conl_q[`PMP_POL_WR] ~^ (strb && !rd_q);
    end
    fn_bus.fn_val[`PMP_PIN_BE] =
      conl_q[`PMP_POL_BE] ~^ (byte_ph && hi_q);
    fn_bus.fn_en[`PMP_PIN_RD] = master && conh_q[`PMP_RDEN];
    fn_bus.fn_en[`PMP_PIN_WR] = master && conh_q[`PMP_WREN];
    fn_bus.fn_en[`PMP_PIN_BE] = master && conh_q[`PMP_BEEN];
    // data pins: address phases, write bytes, released for reads
    fn_bus.fn_en[`PMP_PIN_DAT +: 8] = master ? 8'hFF : 8'h00;
    if (st_q == ST_ALL)
      fn_bus.fn_val[`PMP_PIN_DAT +: 8] = addr_q[7:0];
    else if (st_q == ST_ALH)
      fn_bus.fn_val[`PMP_PIN_DAT +: 8] = hi_addr;
    else
      fn_bus.fn_val[`PMP_PIN_DAT +: 8] = hi_q ? dout_q[15:8] : dout_q[7:0];
    if (!(st_q == ST_ALL || st_q == ST_ALH || (byte_ph && !rd_q)))
      fn_bus.fn_oe[`PMP_PIN_DAT +: 8] = 8'h00;
  end

  pmp_pad #(.N(`PMP_NPIN)) u_pad (
    .clk     (clk),
    .rst_n   (rst_n),
    .fn      (fn_bus.pad),
    .gpio_o  (gpio_o),
    .gpio_oe (gpio_oe),
    .pin_o   (pin_o),
    .pin_oe  (pin_oe)
  );

  // pin slices from the pad flops
  assign address_pins_o        = pin_o[AW-1:0];
  assign address_pins_oe       = pin_oe[AW-1:0];
  assign read_strobe_o         = pin_o[`PMP_PIN_RD];
  assign read_strobe_oe        = pin_oe[`PMP_PIN_RD];
  assign write_strobe_o        = pin_o[`PMP_PIN_WR];
  assign write_strobe_oe       = pin_oe[`PMP_PIN_WR];
  assign byte_enable_strobe_o  = pin_o[`PMP_PIN_BE];
  assign byte_enable_strobe_oe = pin_oe[`PMP_PIN_BE];
  assign port_data_pins_o      = pin_o[`PMP_PIN_DAT +: DW];
  assign port_data_pins_oe     = pin_oe[`PMP_PIN_DAT +: DW];
  assign reg_rdata             = rdata_q;
  assign irq                   = irq_q;

endmodule

// >>> sim/pmp_master_checker.sv
`timescale 1ns/1ps
`include "pmp_cfg.svh"
module pmp_master_checker #(
  parameter int AW = 16
) (
  input wire logic                 clk,
  input wire logic                 rst_n,
  input wire logic [11:0]          reg_addr,
  input wire logic [7:0]           reg_wdata,
  input wire logic                 reg_wr,
  input wire logic                 reg_rd,
  input wire logic [7:0]           reg_rdata,
  input wire logic                 irq,
  input wire logic [AW-1:0]        address_pins_o,
  input wire logic                 read_strobe_o,
  input wire logic                 write_strobe_o,
  input wire logic                 byte_enable_strobe_o,
  input wire logic [`PMP_NPIN-1:0] gpio_o
);
  logic [15:0] en_q;
  logic [7:0]  pie_q;
  logic [7:0]  mask_q;
  logic [7:0]  conh_q;
  logic [7:0]  conl_q;
  logic [7:0]  modeh_q;
  logic [1:0]  live_q;
  logic        idle_c;
  logic        narrow_c;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // shadow of configuration writes
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      en_q    <= 16'h0000;
      pie_q   <= 8'h00;
      mask_q  <= 8'h00;
      conh_q  <= 8'h00;
      conl_q  <= 8'h00;
      modeh_q <= 8'h00;
      live_q  <= 2'h0;
    end
    else
    begin
      live_q <= (live_q == 2'h2) ? live_q : live_q + 2'h1;
      if (reg_wr)
      begin
        case (reg_addr)
          `PMP_OFS_ENL:   en_q[7:0]  <= reg_wdata;
          `PMP_OFS_ENH:   en_q[15:8] <= reg_wdata;
          `PMP_OFS_PIE:   pie_q      <= reg_wdata;
          `PMP_OFS_MASK:  mask_q     <= reg_wdata;
          `PMP_OFS_CONH:  conh_q     <= reg_wdata;
          `PMP_OFS_CONL:  conl_q     <= reg_wdata;
          `PMP_OFS_MODEH: modeh_q    <= reg_wdata;
          default: ;
        endcase
      end
    end
  end

  // outside master operation; master operation with byte-wide data
  assign idle_c   = !(conh_q[7] && modeh_q[1]);
  assign narrow_c = conh_q[7] && modeh_q[1] && !modeh_q[2];

  a_gpio_pass: assert property (
    live_q[1] |-> ((address_pins_o ^ $past(gpio_o[AW-1:0])) & ~$past(en_q) & 16'h3FFC) == 16'h0000)
    else $error("address pin lost its general I/O value");
  a_enable_readback: assert property (
    reg_rd && reg_addr inside {`PMP_OFS_ENL, `PMP_OFS_ENH} |=>
      reg_rdata == ($past(reg_addr[0]) ? $past(en_q[15:8]) : $past(en_q[7:0])))
    else $error("pin enable register read back wrong");
  a_pie_readback: assert property (
    reg_rd && reg_addr == `PMP_OFS_PIE |=> reg_rdata[7] == $past(pie_q[7]))
    else $error("port irq enable bit read back wrong");
  a_unmapped_zero: assert property (
    reg_rd && !(reg_addr inside {[`PMP_OFS_CONH:`PMP_OFS_MASK], `PMP_OFS_PIE}) |=>
      reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_irq_gate: assert property (
    irq |-> $past(pie_q[7]) && $past(mask_q[0]))
    else $error("interrupt without enable and mask");
  a_idle_strobes: assert property (
    live_q[1] && $past(idle_c) |-> write_strobe_o == $past(gpio_o[`PMP_PIN_WR]))
    else $error("write strobe pin not general I/O outside master mode");
  a_narrow_be: assert property (
    live_q[1] && $past(narrow_c) && $past(narrow_c, 2) && $past(conh_q[2]) |->
      byte_enable_strobe_o == !$past(conl_q[2]))
    else $error("byte enable active in byte mode");
  a_split_strobes: assert property (
    $past(conh_q[7] && modeh_q[1:0] == 2'b10 && conh_q[1:0] == 2'b11 && conl_q[1:0] == 2'b11)
      |-> !(read_strobe_o && write_strobe_o))
    else $error("read and write strobes active together");

  c_write: cover property (write_strobe_o && byte_enable_strobe_o);
  c_irq: cover property ($rose(irq));
  c_read: cover property (reg_rd && reg_addr == `PMP_OFS_DATL);
endmodule

// >>> sim/pmp_ext_dev.sv
`timescale 1ns/1ps
// far-side byte memory, second master mode, active-high strobes
module pmp_ext_dev (
  input  wire logic       clk,
  input  wire logic [7:0] addr,
  input  wire logic       rd,
  input  wire logic       wr,
  input  wire logic [7:0] d_o,
  output logic      [7:0] d_i
);
  logic [7:0] mem [256];
  logic [7:0] last_q = 8'hA5;
  logic       hold_q = 1'b0;
  int         k;

  // known contents at start
  initial
  begin
    for (k = 0; k < 256; k++)
      mem[k] = 8'(k);
  end

  // store on write strobe, keep the read byte for one hold cycle
  always @(posedge clk)
  begin
    if (wr === 1'b1)
      mem[addr] <= d_o;
    hold_q <= (rd === 1'b1);
    if (rd === 1'b1)
      last_q <= mem[addr];
  end

  // released bus shows the inverse of the last value
  assign d_i = (rd === 1'b1) ? mem[addr] : (hold_q ? last_q : ~last_q);
endmodule

// >>> sim/test_parallel_master_port_pin_control.sv
`timescale 1ns/1ps
`include "pmp_cfg.svh"
module test_parallel_master_port_pin_control;
  logic        clk;
  logic        rst_n;
  logic [11:0] reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        irq;
  logic [15:0] a_o;
  logic        rd_o;
  logic        wr_o;
  logic        be_o;
  logic [7:0]  d_o;
  logic [7:0]  d_i;
  logic [15:0] a_oe;
  logic        rd_oe;
  logic        wr_oe;
  logic        be_oe;
  logic [7:0]  d_oe;
  logic [26:0] gpio_o;
  logic [26:0] gpio_oe;
  integer      seed = 32'hF7BC6BCB;
  int          num_errors = 0;
  int          check_count = 0;
  int          wr_cnt = 0;
  int          m;
  int          i;
  logic [7:0]  al_seen;
  logic [7:0]  ah_seen;
  logic [7:0]  lo_seen;
  logic [7:0]  hi_seen;
  logic [7:0]  a;
  logic [7:0]  v;
  logic [7:0]  r;
  logic [7:0]  q [4];
  logic [11:0] ofs [4] = '{`PMP_OFS_ENL, `PMP_OFS_ENH, `PMP_OFS_PIE, 12'hF60};

  pmp_master u_pmp_master (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .address_pins_o(a_o), .address_pins_oe(a_oe), .read_strobe_o(rd_o),
    .read_strobe_oe(rd_oe), .write_strobe_o(wr_o), .write_strobe_oe(wr_oe),
    .byte_enable_strobe_o(be_o), .byte_enable_strobe_oe(be_oe),
    .port_data_pins_o(d_o), .port_data_pins_oe(d_oe),
    .port_data_pins_i(d_i), .gpio_o(gpio_o), .gpio_oe(gpio_oe)
  );
  pmp_ext_dev u_pmp_ext_dev (
    .clk(clk), .addr(a_o[7:0]), .rd(rd_o), .wr(wr_o), .d_o(d_o), .d_i(d_i)
  );

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // random general I/O values
  always @(posedge clk)
  begin
    gpio_o  <= 27'($random(seed));
    gpio_oe <= 27'($random(seed));
  end

  // pin monitor, active-high strobes
  always @(posedge clk)
  begin
    if (wr_o === 1'b1)
    begin
      wr_cnt <= wr_cnt + 1;
      if (be_o === 1'b1)
        hi_seen <= d_o;
      else
        lo_seen <= d_o;
    end
    if (a_o[0] === 1'b1)
      al_seen <= d_o;
    if (a_o[1] === 1'b1)
      ah_seen <= d_o;
  end

  task automatic wr(input logic [11:0] ad, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= ad;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] ad, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= ad;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  // poll busy under a bound
  task automatic waitdone();
    int n;
    logic [7:0] s;
    n = 0;
    s = 8'h80;
    while (s[7] !== 1'b0 && n < 40)
    begin
      rd(`PMP_OFS_STAT, s);
      n++;
    end
    chk("busy", 8'h00, {7'h00, s[7]});
  endtask

  task automatic xfer_w(input logic [7:0] ad, input logic [7:0] d);
    wr(`PMP_OFS_ADRL, ad);
    wr(`PMP_OFS_DATL, d);
    waitdone();
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    #100000;
    num_errors++;
    test_done();
  end

  initial
  begin
    rst_n     = 1'b0;
    reg_addr  = 12'h000;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    gpio_o    = 27'h0000000;
    gpio_oe   = 27'h0000000;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    // reset values and an unmapped place
    for (i = 0; i < 4; i++)
    begin
      rd(ofs[i], r);
      chk("reset value", 8'h00, r);
    end
    // random enable patterns read back
    for (i = 0; i < 4; i++)
    begin
      v = 8'($random(seed));
      wr(ofs[i % 2], v);
      rd(ofs[i % 2], r);
      chk("enable", v, r);
    end
    wr(`PMP_OFS_ENL, 8'hFF);
    wr(`PMP_OFS_ENH, 8'hFF);
    // idle strobe levels for both polarities
    wr(`PMP_OFS_CONH, 8'h87);
    wr(`PMP_OFS_MODEH, 8'h02);
    for (m = 0; m < 2; m++)
    begin
      wr(`PMP_OFS_CONL, m ? 8'h0F : 8'h00);
      settle();
      chk("idle level", m ? 8'h00 : 8'h07, {5'h00, rd_o, wr_o, be_o});
    end
    wr(`PMP_OFS_PIE, 8'h80);
    wr(`PMP_OFS_MASK, 8'h01);
    wr(`PMP_OFS_MODEL, 8'h08);
    wr(`PMP_OFS_ADRH, 8'h00);
    wr(`PMP_OFS_MODEH, 8'h02);
    // write transfers land in the far side
    for (i = 0; i < 4; i++)
    begin
      a = 8'($random(seed));
      v = 8'($random(seed));
      xfer_w(a, v);
      chk("far memory", v, u_pmp_ext_dev.mem[a]);
      chk("address pins", a, a_o[7:0]);
      chk("pin drive", 8'h1F, {3'h0, d_oe == 8'h00, &a_oe, rd_oe, wr_oe, be_oe});
      chk("irq", 8'h01, {7'h00, irq});
      wr(`PMP_OFS_STAT, 8'h01);
      settle();
      chk("irq cleared", 8'h00, {7'h00, irq});
    end
    // read transfers from the far side
    for (i = 0; i < 3; i++)
    begin
      a = 8'($random(seed));
      v = 8'($random(seed));
      u_pmp_ext_dev.mem[a] = v;
      m = wr_cnt;
      wr(`PMP_OFS_ADRL, a);
      rd(`PMP_OFS_DATL, r);
      waitdone();
      rd(`PMP_OFS_DATL, r);
      chk("read data", v, r);
      chk("write pin quiet", 8'h00, 8'(wr_cnt - m));
      waitdone();
    end
    // completion with the enable bit clear
    wr(`PMP_OFS_PIE, 8'h00);
    wr(`PMP_OFS_STAT, 8'h01);
    xfer_w(8'h5A, 8'hC3);
    settle();
    chk("irq blocked", 8'h00, {7'h00, irq});
    rd(`PMP_OFS_STAT, r);
    chk("done flag", 8'h01, r & 8'h01);
    // address step up then down
    for (m = 1; m < 3; m++)
    begin
      wr(`PMP_OFS_MODEH, 8'h02 | 8'(m << 3));
      a = 8'($random(seed));
      xfer_w(a, 8'h96);
      rd(`PMP_OFS_ADRL, r);
      chk("address step", (m == 1) ? a + 8'h01 : a - 8'h01, r);
    end
    // first mode: read raises the shared enable pin
    wr(`PMP_OFS_MODEH, 8'h03);
    m = wr_cnt;
    rd(`PMP_OFS_DATL, r);
    waitdone();
    chk("enable strobe", 8'h01, {7'h00, wr_cnt != m});
    // multiplexed address phases with a wide word
    for (m = 1; m < 3; m++)
    begin
      wr(`PMP_OFS_CONH, 8'h87 | 8'(m << 3));
      wr(`PMP_OFS_MODEH, 8'h06);
      wr(`PMP_OFS_CONL, (m == 2) ? 8'hCF : 8'h0F);
      for (i = 0; i < 4; i++)
        q[i] = 8'($random(seed));
      wr(`PMP_OFS_ADRH, q[1]);
      wr(`PMP_OFS_ADRL, q[0]);
      wr(`PMP_OFS_DATH, q[3]);
      wr(`PMP_OFS_DATL, q[2]);
      waitdone();
      chk("latch low", q[0], al_seen);
      if (m == 2)
      begin
        chk("latch high", q[1] & 8'h3F, ah_seen);
        chk("chip selects idle", 8'h03, {6'h00, a_o[15:14]});
      end
      chk("low byte", q[2], lo_seen);
      chk("high byte", q[3], hi_seen);
    end
    test_done();
  end
endmodule

bind pmp_master pmp_master_checker #(.AW(AW)) u_pmp_master_checker (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
  .address_pins_o(address_pins_o), .read_strobe_o(read_strobe_o),
  .write_strobe_o(write_strobe_o), .byte_enable_strobe_o(byte_enable_strobe_o),
  .gpio_o(gpio_o)
);
